//--- arith_pkg.sv
// Opcode patterns, field layout, types and timing counts for the arithmetic decoder
package arith_pkg;
  localparam int BIT_W = 0;
  localparam int BIT_D = 1;
  localparam int BIT_S = 1;
  localparam int MOD_HI = 7;
  localparam int MOD_LO = 6;
  localparam int EXT_HI = 5;
  localparam int EXT_LO = 3;
  localparam logic [1:0] MOD_REGISTER = 2'h3;
  localparam logic [7:0] MASK_DW = 8'hfc;
  localparam logic [7:0] MASK_W = 8'hfe;
  localparam logic [7:0] MASK_S = 8'hfd;
  localparam logic [7:0] MASK_REG = 8'hf8;
  localparam logic [7:0] OPC_SUB_RM = 8'h28;
  localparam logic [7:0] OPC_SUB_ACC = 8'h2c;
  localparam logic [7:0] OPC_BORROW_RM = 8'h18;
  localparam logic [7:0] OPC_BORROW_ACC = 8'h1c;
  localparam logic [7:0] OPC_COMPARE_RM = 8'h38;
  localparam logic [7:0] OPC_COMPARE_ACC = 8'h3c;
  localparam logic [7:0] OPC_IMM_GROUP = 8'h80;
  localparam logic [7:0] OPC_STEP_GROUP = 8'hfe;
  localparam logic [7:0] OPC_STEP_SHORT = 8'h48;
  localparam logic [7:0] OPC_UNARY_GROUP = 8'hf6;
  localparam logic [7:0] OPC_ASCII_ADD = 8'h37;
  localparam logic [7:0] OPC_ASCII_SUB = 8'h3f;
  localparam logic [7:0] OPC_DECIMAL_ADD = 8'h27;
  localparam logic [7:0] OPC_DECIMAL_SUB = 8'h2f;
  localparam logic [7:0] OPC_ESCAPE = 8'h0f;
  localparam logic [7:0] OPC2_SIGNED_MPY = 8'haf;
  localparam logic [7:0] OPC_SIGNED_MPY_IMM = 8'h69;
  localparam logic [2:0] EXT_SUB = 3'h5;
  localparam logic [2:0] EXT_BORROW = 3'h3;
  localparam logic [2:0] EXT_COMPARE = 3'h7;
  localparam logic [2:0] EXT_STEP_DOWN = 3'h1;
  localparam logic [2:0] EXT_SIGN_CHANGE = 3'h3;
  localparam logic [2:0] EXT_UNSIGNED_MPY = 3'h4;
  localparam logic [2:0] EXT_SIGNED_MPY = 3'h5;
  localparam logic [5:0] CLK_ALU_REG = 6'h02;
  localparam logic [5:0] CLK_ADJUST = 6'h04;
  localparam logic [5:0] CLK_MEM_FAST = 6'h05;
  localparam logic [5:0] CLK_MEM_MID = 6'h06;
  localparam logic [5:0] CLK_MEM_SLOW = 6'h07;
  localparam logic [5:0] MPY_LO_REG = 6'h0c;
  localparam logic [5:0] MPY_LO_MEM_BYTE = 6'h0f;
  localparam logic [5:0] MPY_LO_MEM_WORD = 6'h0f;
  localparam logic [5:0] MPY_LO_MEM_DWORD = 6'h11;
  localparam logic [5:0] IMM3_LO_REG = 6'h0d;
  localparam logic [5:0] IMM3_LO_MEM_WORD = 6'h0e;
  localparam logic [5:0] IMM3_LO_MEM_DWORD = 6'h10;
  localparam logic [5:0] SPAN_BYTE = 6'h05;
  localparam logic [5:0] SPAN_WORD = 6'h0d;
  localparam logic [5:0] SPAN_DWORD = 6'h1d;
  localparam logic [1:0] DC_NONE = 2'h0;
  localparam logic [1:0] DC_ONE = 2'h1;
  localparam logic [1:0] DC_TWO = 2'h2;

  typedef enum logic [3:0] {
    unknown_op, subtract_op, subtract_borrow_op, decrement_op, compare_op, sign_change_op,
    ascii_add_adjust_op, ascii_sub_adjust_op, decimal_add_adjust_op, decimal_sub_adjust_op,
    unsigned_multiply_op, signed_multiply_op
  } op_kind_t;
  typedef enum logic [3:0] {
    FORM_NONE, FORM_RM, FORM_IMM, FORM_ACC, FORM_SHORT, FORM_IMPLIED, FORM_GROUP,
    FORM_ESC, FORM_IMM3
  } form_t;
  typedef enum logic [1:0] {WIDTH_BYTE = 2'h0, WIDTH_WORD = 2'h1, WIDTH_DWORD = 2'h2} width_t;
  typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_RUN = 2'h2} state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] opcode2;
    logic [7:0] modrm;
    logic size_32;
  } instr_t;
  typedef struct packed {
    op_kind_t op;
    form_t form;
    logic mem;
    logic full;
    logic sign_ext;
    logic dir;
  } class_t;
  typedef struct packed {
    op_kind_t op;
    width_t width;
    logic mem;
    logic sign_ext;
    logic to_reg;
    logic [5:0] clocks;
    logic [1:0] data_cycles;
  } exec_t;
endpackage

//--- opcode_classify.sv
// Opcode and addressing byte recognition for the arithmetic group
`timescale 1ns/1ps
module opcode_classify (
  input wire arith_pkg::instr_t instr_i,
  output arith_pkg::class_t class_o
);
  wire [7:0] opc = instr_i.opcode;
  wire [2:0] ext = instr_i.modrm[arith_pkg::EXT_HI:arith_pkg::EXT_LO];
  wire mod_mem = instr_i.modrm[arith_pkg::MOD_HI:arith_pkg::MOD_LO] != arith_pkg::MOD_REGISTER;
  wire hit_sub_rm = (opc & arith_pkg::MASK_DW) == arith_pkg::OPC_SUB_RM;
  wire hit_sub_acc = (opc & arith_pkg::MASK_W) == arith_pkg::OPC_SUB_ACC;
  wire hit_borrow_rm = (opc & arith_pkg::MASK_DW) == arith_pkg::OPC_BORROW_RM;
  wire hit_borrow_acc = (opc & arith_pkg::MASK_W) == arith_pkg::OPC_BORROW_ACC;
  wire hit_compare_rm = (opc & arith_pkg::MASK_DW) == arith_pkg::OPC_COMPARE_RM;
  wire hit_compare_acc = (opc & arith_pkg::MASK_W) == arith_pkg::OPC_COMPARE_ACC;
  wire hit_imm = (opc & arith_pkg::MASK_DW) == arith_pkg::OPC_IMM_GROUP;
  wire hit_step = (opc & arith_pkg::MASK_W) == arith_pkg::OPC_STEP_GROUP;
  wire hit_short = (opc & arith_pkg::MASK_REG) == arith_pkg::OPC_STEP_SHORT;
  wire hit_unary = (opc & arith_pkg::MASK_W) == arith_pkg::OPC_UNARY_GROUP;
  wire hit_esc = (opc == arith_pkg::OPC_ESCAPE) && (instr_i.opcode2 == arith_pkg::OPC2_SIGNED_MPY);
  wire hit_imm3 = (opc & arith_pkg::MASK_S) == arith_pkg::OPC_SIGNED_MPY_IMM;
  wire hit_rm = hit_sub_rm | hit_borrow_rm | hit_compare_rm;
  wire hit_acc = hit_sub_acc | hit_borrow_acc | hit_compare_acc;
  wire hit_adjust = (opc == arith_pkg::OPC_ASCII_ADD) | (opc == arith_pkg::OPC_ASCII_SUB) |
                    (opc == arith_pkg::OPC_DECIMAL_ADD) | (opc == arith_pkg::OPC_DECIMAL_SUB);
  // Groups are only claimed for the middle fields this block owns
  wire grp_ok = (hit_imm && (ext == arith_pkg::EXT_SUB || ext == arith_pkg::EXT_BORROW ||
                 ext == arith_pkg::EXT_COMPARE)) || (hit_step && ext == arith_pkg::EXT_STEP_DOWN) ||
                (hit_unary && (ext == arith_pkg::EXT_SIGN_CHANGE ||
                 ext == arith_pkg::EXT_UNSIGNED_MPY || ext == arith_pkg::EXT_SIGNED_MPY));
  wire imm_sub = hit_imm && ext == arith_pkg::EXT_SUB;
  wire imm_borrow = hit_imm && ext == arith_pkg::EXT_BORROW;
  wire imm_compare = hit_imm && ext == arith_pkg::EXT_COMPARE;
  wire un_sign_flip = hit_unary && ext == arith_pkg::EXT_SIGN_CHANGE;
  wire un_umpy = hit_unary && ext == arith_pkg::EXT_UNSIGNED_MPY;
  wire un_smpy = hit_unary && ext == arith_pkg::EXT_SIGNED_MPY;
  wire with_modrm = hit_rm | (hit_imm & grp_ok) | ((hit_step | hit_unary) & grp_ok) |
                    hit_esc | hit_imm3;

  assign class_o.op =
    (hit_sub_rm | hit_sub_acc | imm_sub) ? arith_pkg::subtract_op :
    (hit_borrow_rm | hit_borrow_acc | imm_borrow) ? arith_pkg::subtract_borrow_op :
    ((hit_step & grp_ok) | hit_short) ? arith_pkg::decrement_op :
    (hit_compare_rm | hit_compare_acc | imm_compare) ? arith_pkg::compare_op :
    un_sign_flip ? arith_pkg::sign_change_op :
    (opc == arith_pkg::OPC_ASCII_ADD) ? arith_pkg::ascii_add_adjust_op :
    (opc == arith_pkg::OPC_ASCII_SUB) ? arith_pkg::ascii_sub_adjust_op :
    (opc == arith_pkg::OPC_DECIMAL_ADD) ? arith_pkg::decimal_add_adjust_op :
    (opc == arith_pkg::OPC_DECIMAL_SUB) ? arith_pkg::decimal_sub_adjust_op :
    un_umpy ? arith_pkg::unsigned_multiply_op :
    (un_smpy | hit_esc | hit_imm3) ? arith_pkg::signed_multiply_op : arith_pkg::unknown_op;
  assign class_o.form =
    hit_rm ? arith_pkg::FORM_RM :
    (hit_imm & grp_ok) ? arith_pkg::FORM_IMM :
    hit_acc ? arith_pkg::FORM_ACC :
    hit_short ? arith_pkg::FORM_SHORT :
    hit_adjust ? arith_pkg::FORM_IMPLIED :
    ((hit_step | hit_unary) & grp_ok) ? arith_pkg::FORM_GROUP :
    hit_esc ? arith_pkg::FORM_ESC :
    hit_imm3 ? arith_pkg::FORM_IMM3 : arith_pkg::FORM_NONE;
  assign class_o.mem = with_modrm & mod_mem;
  assign class_o.full = hit_esc | hit_imm3 | hit_short | (~hit_adjust & opc[arith_pkg::BIT_W]);
  assign class_o.sign_ext = (hit_imm | hit_imm3) & opc[arith_pkg::BIT_S];
  assign class_o.dir = hit_rm & opc[arith_pkg::BIT_D];
endmodule

//--- exec_cycle_counter.sv
// Down counter that measures out the execution clocks of one instruction
`timescale 1ns/1ps
module exec_cycle_counter (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire load_i,
  input wire [5:0] load_value_i,
  output logic last_o
);
  logic [5:0] count;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 6'h00;
    end else if (load_i) begin
      count <= load_value_i;
    end else if (count != 6'h00) begin
      count <= count - 6'h01;
    end
  end

  assign last_o = count == 6'h01;
endmodule

//--- sub_cmp_mul_decode_timing.sv
// Arithmetic group decoder with execution clock and data cycle sequencing
`timescale 1ns/1ps
// Notes on behaviour
// - Subtract memory from register: 6 clocks, 1 data.
// - Subtract register from memory: 7 clocks, 2 data.
// - Immediate subtract: 2 or 7 clocks, 0/1 data.
// - Borrow subtract register-register: 2 clocks, no data.
// - Borrow subtract memory from register: 6 clocks, 1 data.
// - Borrow subtract register from memory: 7 clocks, 2 data.
// - Immediate borrow subtract: 2 or 7 clocks, 0/2.
// - Accumulator immediate borrow subtract: 2 clocks.
// - Decrement register/memory: 2 or 6 clocks, 0/2.
// - Compare register with register: 2 clocks, no data.
// - Compare memory with register: 5 clocks, 1 data.
// - Compare register with memory: 6 clocks, 2 data.
// - Immediate compare: 2 or 5 clocks, 0/1.
// - Sign change: 2 or 6 clocks, 0/2 data.
// - ASCII adjusts take 4 clocks each.
// - Decimal adjusts take 4 clocks each.
// - Unsigned accumulator multiply, operand-dependent clock ranges.
// - Signed accumulator multiply, same ranges, 0 data for register, 1 for byte/word memory, 2 for doubleword memory.
// - Two-byte signed register multiply, variable clocks.
// - Signed immediate multiply: 13-26/14-27, 13-42/16-45.
module sub_cmp_mul_decode_timing (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire start_i,
  input wire arith_pkg::instr_t instr_i,
  input wire [31:0] mult_value_i,
  output logic busy_o,
  output logic done_o,
  output logic illegal_o,
  output logic data_cycle_o,
  output arith_pkg::exec_t exec_o
);

  arith_pkg::class_t cls;
  arith_pkg::state_t state;
  arith_pkg::state_t next_state;
  arith_pkg::exec_t next_exec;
  logic [1:0] data_left;
  logic last_clock;

  opcode_classify u_classify (
    .instr_i(instr_i),
    .class_o(cls)
  );

  // Highest set bit; the multiplier ends early on small operands
  function automatic logic [4:0] msb_index(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  // Operand magnitude at its width, two's complement undone for signed forms
  function automatic logic [31:0] magnitude(input logic [31:0] v, input arith_pkg::width_t w,
                                            input logic signed_op);
    logic [31:0] m;
    m = v;
    case (w)
      arith_pkg::WIDTH_BYTE: begin
        m = {24'h00_0000, (signed_op && v[7]) ? (~v[7:0] + 8'h01) : v[7:0]};
      end
      arith_pkg::WIDTH_WORD: begin
        m = {16'h0000, (signed_op && v[15]) ? (~v[15:0] + 16'h0001) : v[15:0]};
      end
      default: begin
        m = (signed_op && v[31]) ? (~v + 32'h0000_0001) : v;
      end
    endcase
    return m;
  endfunction

  function automatic logic [5:0] mpy_span(input arith_pkg::width_t w);
    logic [5:0] s;
    case (w)
      arith_pkg::WIDTH_BYTE: s = arith_pkg::SPAN_BYTE;
      arith_pkg::WIDTH_WORD: s = arith_pkg::SPAN_WORD;
      default: s = arith_pkg::SPAN_DWORD;
    endcase
    return s;
  endfunction

  // Fixed-time forms; multiply is handled apart
  function automatic logic [5:0] alu_clocks(input arith_pkg::class_t c);
    logic [5:0] n;
    n = arith_pkg::CLK_ALU_REG;
    case (c.form)
      arith_pkg::FORM_RM: begin
        if (!c.mem) begin
          n = arith_pkg::CLK_ALU_REG;
        end else if (c.op == arith_pkg::compare_op) begin
          n = c.dir ? arith_pkg::CLK_MEM_MID : arith_pkg::CLK_MEM_FAST;
        end else begin
          n = c.dir ? arith_pkg::CLK_MEM_MID : arith_pkg::CLK_MEM_SLOW;
        end
      end
      arith_pkg::FORM_IMM: begin
        if (!c.mem) begin
          n = arith_pkg::CLK_ALU_REG;
        end else if (c.op == arith_pkg::compare_op) begin
          n = arith_pkg::CLK_MEM_FAST;
        end else begin
          n = arith_pkg::CLK_MEM_SLOW;
        end
      end
      arith_pkg::FORM_IMPLIED: begin
        n = arith_pkg::CLK_ADJUST;
      end
      arith_pkg::FORM_GROUP: begin
        n = c.mem ? arith_pkg::CLK_MEM_MID : arith_pkg::CLK_ALU_REG;
      end
      default: begin
        n = arith_pkg::CLK_ALU_REG;
      end
    endcase
    return n;
  endfunction

  function automatic logic [1:0] alu_data(input arith_pkg::class_t c);
    logic [1:0] d;
    d = arith_pkg::DC_NONE;
    case (c.form)
      arith_pkg::FORM_RM: begin
        if (!c.mem) begin
          d = arith_pkg::DC_NONE;
        end else if (c.op == arith_pkg::compare_op) begin
          d = c.dir ? arith_pkg::DC_TWO : arith_pkg::DC_ONE;
        end else begin
          d = c.dir ? arith_pkg::DC_ONE : arith_pkg::DC_TWO;
        end
      end
      arith_pkg::FORM_IMM: begin
        if (!c.mem) begin
          d = arith_pkg::DC_NONE;
        end else if (c.op == arith_pkg::subtract_borrow_op) begin
          d = arith_pkg::DC_TWO;
        end else begin
          d = arith_pkg::DC_ONE;
        end
      end
      arith_pkg::FORM_GROUP: begin
        d = c.mem ? arith_pkg::DC_TWO : arith_pkg::DC_NONE;
      end
      default: begin
        d = arith_pkg::DC_NONE;
      end
    endcase
    return d;
  endfunction

  // Lowest multiply time for the form, width and operand place
  function automatic logic [5:0] mpy_base(input arith_pkg::class_t c, input arith_pkg::width_t w);
    logic [5:0] b;
    if (c.form == arith_pkg::FORM_IMM3) begin
      if (!c.mem) begin
        b = arith_pkg::IMM3_LO_REG;
      end else if (w == arith_pkg::WIDTH_DWORD) begin
        b = arith_pkg::IMM3_LO_MEM_DWORD;
      end else begin
        b = arith_pkg::IMM3_LO_MEM_WORD;
      end
    end else if (!c.mem) begin
      b = arith_pkg::MPY_LO_REG;
    end else begin
      case (w)
        arith_pkg::WIDTH_BYTE: b = arith_pkg::MPY_LO_MEM_BYTE;
        arith_pkg::WIDTH_WORD: b = arith_pkg::MPY_LO_MEM_WORD;
        default: b = arith_pkg::MPY_LO_MEM_DWORD;
      endcase
    end
    return b;
  endfunction

  // width from the full flag (low opcode bit, fixed for short, escape, imm3 and adjust forms) and size
  wire arith_pkg::width_t width = !cls.full ? arith_pkg::WIDTH_BYTE :
                                  instr_i.size_32 ? arith_pkg::WIDTH_DWORD :
                                  arith_pkg::WIDTH_WORD;
  wire is_mpy = cls.op == arith_pkg::unsigned_multiply_op ||
                cls.op == arith_pkg::signed_multiply_op;
  wire mpy_signed = cls.op == arith_pkg::signed_multiply_op;
  wire [4:0] mpy_msb = msb_index(magnitude(mult_value_i, width, mpy_signed));
  wire [5:0] span = mpy_span(width);
  wire [5:0] mpy_extra = ({1'b0, mpy_msb} > span) ? span : {1'b0, mpy_msb};
  wire [5:0] mpy_clocks = mpy_base(cls, width) + mpy_extra;
  wire [1:0] mpy_data = !cls.mem ? arith_pkg::DC_NONE :
                        (width == arith_pkg::WIDTH_DWORD) ? arith_pkg::DC_TWO :
                        arith_pkg::DC_ONE;
  wire known = cls.op != arith_pkg::unknown_op;

  assign next_exec.op = cls.op;
  assign next_exec.width = width;
  assign next_exec.mem = cls.mem;
  assign next_exec.sign_ext = cls.sign_ext;
  assign next_exec.to_reg = (cls.form == arith_pkg::FORM_RM) ? cls.dir :
                            (cls.form == arith_pkg::FORM_ESC ||
                             cls.form == arith_pkg::FORM_IMM3) ? 1'b1 : !cls.mem;
  assign next_exec.clocks = is_mpy ? mpy_clocks : alu_clocks(cls);
  assign next_exec.data_cycles = is_mpy ? mpy_data : alu_data(cls);

  // Requests during execution are dropped, not queued
  wire accept = (state == arith_pkg::ST_IDLE) && start_i;
  wire load = accept && known;
  wire finish = (state == arith_pkg::ST_RUN) && last_clock;

  exec_cycle_counter u_counter (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .load_i(load),
    .load_value_i(next_exec.clocks),
    .last_o(last_clock)
  );

  always_comb begin
    next_state = state;
    case (state)
      arith_pkg::ST_IDLE: begin
        if (load) begin
          next_state = arith_pkg::ST_RUN;
        end
      end
      arith_pkg::ST_RUN: begin
        if (finish) begin
          next_state = arith_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = arith_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= arith_pkg::ST_IDLE;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
    end else begin
      state <= next_state;
      busy_o <= next_state == arith_pkg::ST_RUN;
      done_o <= finish;
      illegal_o <= accept && !known;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      exec_o <= '0;
    end else if (load) begin
      exec_o <= next_exec;
    end
  end

  // Data cycles go out first; no form has more data cycles than clocks
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_left <= arith_pkg::DC_NONE;
      data_cycle_o <= 1'b0;
    end else if (load) begin
      data_cycle_o <= next_exec.data_cycles != arith_pkg::DC_NONE;
      data_left <= (next_exec.data_cycles != arith_pkg::DC_NONE) ?
                   next_exec.data_cycles - arith_pkg::DC_ONE : arith_pkg::DC_NONE;
    end else begin
      data_cycle_o <= data_left != arith_pkg::DC_NONE;
      if (data_left != arith_pkg::DC_NONE) begin
        data_left <= data_left - arith_pkg::DC_ONE;
      end
    end
  end
endmodule

//--- sub_cmp_mul_decode_timing_properties.sv
// Concurrent checks on the arithmetic decoder ports
`timescale 1ns/1ps
module decode_timing_checker (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire start_i,
  input wire arith_pkg::instr_t instr_i,
  input wire [31:0] mult_value_i,
  input wire busy_o,
  input wire done_o,
  input wire illegal_o,
  input wire data_cycle_o,
  input wire arith_pkg::exec_t exec_o
);
  logic [5:0] busy_cnt;
  logic [2:0] dc_cnt;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Counts restart whenever busy drops, so the done cycle shows the totals
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_cnt <= 6'h00;
      dc_cnt <= 3'h0;
    end else begin
      busy_cnt <= busy_o ? busy_cnt + 6'h01 : 6'h00;
      dc_cnt <= busy_o ? dc_cnt + {2'h0, data_cycle_o} : 3'h0;
    end
  end
  a_start_answer: assert property (
    start_i && !busy_o |=> busy_o != illegal_o) else $error("start not answered");
  a_busy_length: assert property (
    done_o |-> busy_cnt == exec_o.clocks) else $error("busy length differs from clocks");
  a_done_after: assert property (
    $fell(busy_o) |-> done_o ##1 !done_o) else $error("done missing after busy");
  a_data_total: assert property (
    done_o |-> {1'b0, dc_cnt[1:0]} == {1'b0, exec_o.data_cycles}) else $error("data count");
  a_data_first: assert property (
    $rose(busy_o) |-> data_cycle_o == (exec_o.data_cycles != 2'h0)) else $error("data start");
  a_reg_fast: assert property (
    $rose(busy_o) && !exec_o.mem
    && exec_o.op inside {[arith_pkg::subtract_op:arith_pkg::sign_change_op]}
    |-> exec_o.clocks == 6'h02 && exec_o.data_cycles == 2'h0) else $error("register timing");
  a_adjust_four: assert property (
    $rose(busy_o)
    && exec_o.op inside {[arith_pkg::ascii_add_adjust_op:arith_pkg::decimal_sub_adjust_op]}
    |-> exec_o.clocks == 6'h04 && exec_o.data_cycles == 2'h0) else $error("adjust timing");
  a_mpy_window: assert property (
    $rose(busy_o)
    && exec_o.op inside {[arith_pkg::unsigned_multiply_op:arith_pkg::signed_multiply_op]}
    |-> exec_o.clocks inside {[6'h0c:6'h2e]}) else $error("multiply clocks out of range");
  a_exec_hold: assert property (
    !$rose(busy_o) |-> $stable(exec_o)) else $error("exec changed without a start");
  a_illegal_pulse: assert property (
    illegal_o |-> !busy_o ##1 !illegal_o && !busy_o) else $error("illegal pulse wrong");
  c_illegal: cover property (illegal_o);
  c_mem_run: cover property (done_o && exec_o.mem);
  c_back_to_back: cover property (done_o && start_i ##1 busy_o);
endmodule

//--- fetch_bus_model.sv
// Instruction and operand supplier that releases its lines between fetches
`timescale 1ns/1ps
module fetch_bus_model (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire load_i,
  input wire arith_pkg::instr_t instr_i,
  input wire [31:0] mult_value_i,
  output arith_pkg::instr_t instr_o,
  output logic [31:0] mult_value_o
);
  // Released lines toggle every cycle so a sample one cycle late never looks right
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      instr_o <= '0;
      mult_value_o <= 32'h0000_0000;
    end else if (load_i) begin
      instr_o <= instr_i;
      mult_value_o <= mult_value_i;
    end else begin
      instr_o <= ~instr_o;
      mult_value_o <= ~mult_value_o;
    end
  end
endmodule

//--- test_sub_cmp_mul_decode_timing.sv
// Self-checking bench for the arithmetic decoder and its timing
`timescale 1ns/1ps
module test_sub_cmp_mul_decode_timing;
  logic clk_sys_i, rst_n_i, start_i, ld, busy_o, done_o, illegal_o, data_cycle_o;
  logic [31:0] mv, mult_value_i;
  arith_pkg::instr_t ins, instr_i;
  arith_pkg::exec_t exec_o;
  int n_errors = 0;
  int total_checks = 0;
  int nb, nd;
  fetch_bus_model bus (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .load_i(ld), .instr_i(ins),
    .mult_value_i(mv), .instr_o(instr_i), .mult_value_o(mult_value_i));
  sub_cmp_mul_decode_timing dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .start_i(start_i),
    .instr_i(instr_i), .mult_value_i(mult_value_i), .busy_o(busy_o), .done_o(done_o),
    .illegal_o(illegal_o), .data_cycle_o(data_cycle_o), .exec_o(exec_o));
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // Start one instruction and count busy and data cycles up to done or illegal
  task automatic go(input logic [7:0] o1, o2, m, input logic s32, input logic [31:0] v);
    int k;
    @(posedge clk_sys_i);
    ld <= 1'b1;
    ins <= '{o1, o2, m, s32};
    mv <= v;
    @(posedge clk_sys_i);
    ld <= 1'b0;
    start_i <= 1'b1;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    nb = 0;
    nd = 0;
    for (k = 0; k < 60; k++) begin
      #1;
      if (done_o === 1'b1 || illegal_o === 1'b1) break;
      nb += int'(busy_o);
      nd += int'(data_cycle_o);
      @(posedge clk_sys_i);
    end
    // Running out of the window counts as a mismatch
    chk("end pulse", 1, k < 60);
  endtask
  task automatic seen(input arith_pkg::op_kind_t op, input logic [5:0] c, input logic [1:0] d);
    chk("op", op, exec_o.op);
    chk("clocks", c, exec_o.clocks);
    chk("data cycles", d, exec_o.data_cycles);
    chk("busy span", c, nb);
    chk("data pulses", d, nd);
  endtask
  task automatic run(input logic [7:0] o1, m, input arith_pkg::op_kind_t op,
    input logic [5:0] c, input logic [1:0] d);
    go(o1, 8'h00, m, 1'b1, 32'h0000_0001);
    seen(op, c, d);
  endtask
  task automatic t_subtract;
    run(8'h28, 8'h00, arith_pkg::subtract_op, 6'h07, 2'h2);
    chk("memory operand", 1, exec_o.mem);
    chk("to register", 0, exec_o.to_reg);
    run(8'h2b, 8'h06, arith_pkg::subtract_op, 6'h06, 2'h1);
    chk("to register", 1, exec_o.to_reg);
    run(8'h83, 8'h28, arith_pkg::subtract_op, 6'h07, 2'h1);
    chk("sign extend", 1, exec_o.sign_ext);
    run(8'h80, 8'he8, arith_pkg::subtract_op, 6'h02, 2'h0);
    chk("width", arith_pkg::WIDTH_BYTE, exec_o.width);
    chk("memory operand", 0, exec_o.mem);
    $display("test subtract finished, mismatches %0d", n_errors);
  endtask
  task automatic t_borrow;
    run(8'h18, 8'h00, arith_pkg::subtract_borrow_op, 6'h07, 2'h2);
    run(8'h1a, 8'h05, arith_pkg::subtract_borrow_op, 6'h06, 2'h1);
    run(8'h1b, 8'hc0, arith_pkg::subtract_borrow_op, 6'h02, 2'h0);
    run(8'h80, 8'h18, arith_pkg::subtract_borrow_op, 6'h07, 2'h2);
    run(8'h83, 8'hd8, arith_pkg::subtract_borrow_op, 6'h02, 2'h0);
    run(8'h1c, 8'h00, arith_pkg::subtract_borrow_op, 6'h02, 2'h0);
    $display("test borrow finished, mismatches %0d", n_errors);
  endtask
  task automatic t_compare_step;
    run(8'h38, 8'h00, arith_pkg::compare_op, 6'h05, 2'h1);
    run(8'h3b, 8'h00, arith_pkg::compare_op, 6'h06, 2'h2);
    run(8'h39, 8'hc0, arith_pkg::compare_op, 6'h02, 2'h0);
    run(8'h81, 8'h38, arith_pkg::compare_op, 6'h05, 2'h1);
    run(8'h83, 8'hf8, arith_pkg::compare_op, 6'h02, 2'h0);
    run(8'hff, 8'h08, arith_pkg::decrement_op, 6'h06, 2'h2);
    run(8'hfe, 8'hc8, arith_pkg::decrement_op, 6'h02, 2'h0);
    run(8'h4b, 8'h00, arith_pkg::decrement_op, 6'h02, 2'h0);
    chk("short width", arith_pkg::WIDTH_DWORD, exec_o.width);
    run(8'hf7, 8'h18, arith_pkg::sign_change_op, 6'h06, 2'h2);
    run(8'hf6, 8'hd8, arith_pkg::sign_change_op, 6'h02, 2'h0);
    run(8'h37, 8'h00, arith_pkg::ascii_add_adjust_op, 6'h04, 2'h0);
    run(8'h3f, 8'h00, arith_pkg::ascii_sub_adjust_op, 6'h04, 2'h0);
    run(8'h27, 8'h00, arith_pkg::decimal_add_adjust_op, 6'h04, 2'h0);
    run(8'h2f, 8'h00, arith_pkg::decimal_sub_adjust_op, 6'h04, 2'h0);
    $display("test compare and unary finished, mismatches %0d", n_errors);
  endtask
  task automatic t_multiply;
    go(8'hf6, 8'h00, 8'he0, 1'b1, 32'h0000_00ff);
    seen(arith_pkg::unsigned_multiply_op, 6'h11, 2'h0);
    go(8'hf7, 8'h00, 8'h20, 1'b1, 32'h8000_0000);
    seen(arith_pkg::unsigned_multiply_op, 6'h2e, 2'h2);
    go(8'hf7, 8'h00, 8'he8, 1'b0, 32'h0000_ffff);
    seen(arith_pkg::signed_multiply_op, 6'h0c, 2'h0);
    go(8'hf7, 8'h00, 8'h28, 1'b1, 32'hffff_fffe);
    seen(arith_pkg::signed_multiply_op, 6'h12, 2'h2);
    go(8'h0f, 8'haf, 8'h06, 1'b0, 32'h0000_0100);
    seen(arith_pkg::signed_multiply_op, 6'h17, 2'h1);
    go(8'h69, 8'h00, 8'hc0, 1'b1, 32'h0000_1000);
    seen(arith_pkg::signed_multiply_op, 6'h19, 2'h0);
    chk("width", arith_pkg::WIDTH_DWORD, exec_o.width);
    go(8'h6b, 8'h00, 8'h06, 1'b0, 32'h0000_7fff);
    seen(arith_pkg::signed_multiply_op, 6'h1b, 2'h1);
    chk("sign extend", 1, exec_o.sign_ext);
    $display("test multiply finished, mismatches %0d", n_errors);
  endtask
  // Other middle field refused; then starts held high run back to back
  task automatic t_refuse_and_chain;
    run(8'h39, 8'hc0, arith_pkg::compare_op, 6'h02, 2'h0);
    go(8'h80, 8'h00, 8'h08, 1'b1, 32'h0000_0001);
    chk("illegal", 1, illegal_o);
    chk("kept clocks", 6'h02, exec_o.clocks);
    @(posedge clk_sys_i);
    ld <= 1'b1;
    ins <= '{8'h2b, 8'h00, 8'hc0, 1'b1};
    @(posedge clk_sys_i);
    start_i <= 1'b1;
    nb = 0;
    nd = 0;
    repeat (9) begin
      @(posedge clk_sys_i);
      #1;
      nb += int'(busy_o);
      nd += int'(done_o);
    end
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    ld <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk("chain busy", 6, nb);
    chk("chain done", 3, nd);
    $display("test refusal and chaining finished, mismatches %0d", n_errors);
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_errors++;
    report_and_stop;
  end
  initial begin
    rst_n_i = 1'b0;
    start_i = 1'b0;
    ld = 1'b0;
    ins = '0;
    mv = 32'h0000_0000;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_subtract;
    t_borrow;
    t_compare_step;
    t_multiply;
    t_refuse_and_chain;
    report_and_stop;
  end
endmodule
bind sub_cmp_mul_decode_timing decode_timing_checker watch (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .start_i(start_i), .instr_i(instr_i), .mult_value_i(mult_value_i),
  .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o), .data_cycle_o(data_cycle_o),
  .exec_o(exec_o));
